/* design/css_supervisor.sv */
`timescale 1ns/100ps
module css_supervisor
  import css_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int INT_CYCLES = INT_PULSE_CYC,
  parameter int WDOG_TICKS = WDOG_MS,
  parameter int SAFE_T0 = SAFE_MS_0,
  parameter int SAFE_T1 = SAFE_MS_1,
  parameter int SAFE_T2 = SAFE_MS_2,
  parameter int SAFE_T3 = SAFE_MS_3
)(
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // power, chip control and charge progress
  input wire logic vin_present_i,
  input wire logic chip_disable_in_i,
  input wire logic charge_req_i,
  input wire logic precharge_i,
  input wire logic terminated_i,
  input wire logic cc_cv_loop_i,
  // host bus events and mode
  input wire logic i2c_txn_i,
  input wire logic i2c_write_i,
  input wire logic hiz_mode_i,
  // configuration
  input wire logic [1:0] safety_duration_field_i,
  input wire logic slow_timer_enable_i,
  input wire logic [2:0] input_limit_pin_reg_code_i,
  input wire logic [2:0] input_limit_pin_code_i,
  input wire logic input_limit_pin_gnd_i,
  input wire logic charge_set_pin_gnd_i,
  input wire logic [12:0] batreg_mv_i,
  // temperature comparators, asynchronous levels
  input wire logic die_hot_i,
  input wire logic die_cooled_i,
  input wire logic thermistor_off_level_i,
  input wire logic ts_hot_i,
  input wire logic ts_cold_i,
  input wire logic ts_cool_i,
  input wire logic ts_warm_i,
  // charge control
  output logic charge_en_o,
  output logic [2:0] charge_state_o,
  output logic safety_fault_o,
  output logic int_o,
  output logic half_current_o,
  output logic [12:0] batreg_mv_o,
  output logic charge_set_pin_use_reg_o,
  output logic input_limit_pin_use_reg_o,
  output logic [2:0] input_limit_pin_code_o,
  output logic [8:0] input_limit_pin_ma_o,
  // rails
  output logic mid_rail_output_en_o,
  output logic buck_system_output_en_o,
  output logic aux_switch_output_en_o,
  // host side
  output logic host_mode_o,
  output logic wdog_run_o,
  output logic defaults_reload_o
);
  function automatic logic [31:0] safe_limit(input logic [1:0] f);
    case (f)
      2'h0: safe_limit = 32'(SAFE_T0);
      2'h1: safe_limit = 32'(SAFE_T1);
      2'h2: safe_limit = 32'(SAFE_T2);
      default: safe_limit = 32'(SAFE_T3);
    endcase
  endfunction
  // ==========================================
  // synchronisers
  logic [SY_N-1:0] sy_raw, sy1_q, sy2_q;
  assign sy_raw = {ts_warm_i, ts_cool_i, ts_cold_i, ts_hot_i, thermistor_off_level_i,
                   die_cooled_i, die_hot_i};
  genvar g;
  generate
    for (g = 0; g < SY_N; g++)
    begin : g_sync
      // no reset: a reset of two or more cycles flushes both stages
      always_ff @(posedge mclk_i)
      begin
        sy1_q[g] <= sy_raw[g];
        sy2_q[g] <= sy1_q[g];
      end
    end
  endgenerate
  // ==========================================
  // temperature qualification
  logic ts_qual, ts_suspend, ts_cool_zone, ts_warm_zone, ot_q, ot_d;
  assign ts_qual = !sy2_q[SY_THERMISTOR_OFF_LEVEL];
  assign ts_suspend = ts_qual && (sy2_q[SY_TS_HOT] || sy2_q[SY_TS_COLD]);
  assign ts_cool_zone = ts_qual && sy2_q[SY_TS_COOL] && !sy2_q[SY_TS_COLD];
  assign ts_warm_zone = ts_qual && sy2_q[SY_TS_WARM] && !sy2_q[SY_TS_HOT];
  // cooled comparator trips at shutdown minus hysteresis; heating wins a tie
  assign ot_d = sy2_q[SY_DIE_HOT] || (ot_q && !sy2_q[SY_DIE_COOLED]);
  logic [12:0] batreg_d;
  localparam logic [12:0] BR_FLOOR = 13'(BATREG_FLOOR_MV);
  localparam logic [12:0] BR_DROP = 13'(BATREG_DROP_MV);
  assign batreg_d = !ts_warm_zone ? batreg_mv_i :
                    (batreg_mv_i > BR_FLOOR + BR_DROP) ? batreg_mv_i - BR_DROP :
                    (batreg_mv_i > BR_FLOOR) ? BR_FLOOR : batreg_mv_i;
  // ==========================================
  // time base
  logic [31:0] tick_cnt_q;
  logic tick, half_q;
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      tick_cnt_q <= 32'h0;
      half_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      half_q <= half_q ^ tick;
    end
  end
  // ==========================================
  // charge sequence and safety timer
  css_state_t state_q, state_d;
  logic [31:0] safe_cnt_q, limit, pre_limit;
  logic [1:0] dur_q;
  logic fault_q, fault_set, fault_d, cd_q, vin_q, toggle;
  logic allowed, running, restart, advance;
  assign allowed = charge_req_i && vin_present_i && !chip_disable_in_i && !ot_q;
  assign running = (state_q == CSS_PRE) || (state_q == CSS_FAST);
  assign restart = !running || ot_q || (dur_q != safety_duration_field_i);
  // slow option only advances on alternate ticks outside cc/cv control
  assign advance = tick && !ts_suspend &&
                   (!slow_timer_enable_i || cc_cv_loop_i || half_q);
  assign limit = safe_limit(safety_duration_field_i);
  assign pre_limit = limit / 32'(PRE_DIV);
  assign fault_set = running && !restart && !terminated_i &&
                     ((state_q == CSS_PRE && safe_cnt_q >= pre_limit) ||
                      safe_cnt_q >= limit);
  assign toggle = (cd_q != chip_disable_in_i) || (vin_q != vin_present_i);
  assign fault_d = fault_set || (fault_q && !toggle);
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CSS_IDLE:
        if (allowed && !fault_q)
          state_d = precharge_i ? CSS_PRE : CSS_FAST;
      CSS_PRE:
        if (!allowed || fault_set)
          state_d = CSS_IDLE;
        else if (terminated_i)
          state_d = CSS_DONE;
        else if (!precharge_i)
          state_d = CSS_FAST;
      CSS_FAST:
        if (!allowed || fault_set)
          state_d = CSS_IDLE;
        else if (terminated_i)
          state_d = CSS_DONE;
      CSS_DONE:
        if (!allowed)
          state_d = CSS_IDLE;
      default:
        state_d = CSS_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_q <= CSS_IDLE;
      safe_cnt_q <= 32'h0;
      dur_q <= 2'h0;
      fault_q <= 1'b0;
      // start from the live levels so the release of reset is not taken for a toggle
      cd_q <= chip_disable_in_i;
      vin_q <= vin_present_i;
      ot_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      safe_cnt_q <= restart ? 32'h0 : safe_cnt_q + {31'h0, advance};
      dur_q <= safety_duration_field_i;
      fault_q <= fault_d;
      cd_q <= chip_disable_in_i;
      vin_q <= vin_present_i;
      ot_q <= ot_d;
    end
  end
  // ==========================================
  // interrupt pulse
  logic [31:0] int_cnt_q, int_cnt_d;
  assign int_cnt_d = fault_set && !fault_q ? 32'(INT_CYCLES) :
                     (int_cnt_q != 32'h0) ? int_cnt_q - 32'h1 : 32'h0;
  // ==========================================
  // host mode and watchdog
  logic host_q, wd_run_q, wd_expire;
  logic [31:0] wd_cnt_q;
  assign wd_expire = wd_run_q && tick && (wd_cnt_q == 32'(WDOG_TICKS - 1));
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      host_q <= 1'b0;
      wd_run_q <= 1'b0;
      wd_cnt_q <= 32'h0;
      int_cnt_q <= 32'h0;
    end
    else
    begin
      // a write in the expiry cycle keeps host mode
      host_q <= i2c_write_i || (host_q && !wd_expire);
      wd_run_q <= !hiz_mode_i && (i2c_txn_i || (wd_run_q && !wd_expire));
      wd_cnt_q <= (i2c_txn_i || !wd_run_q || wd_expire) ? 32'h0 :
                  wd_cnt_q + {31'h0, tick};
      int_cnt_q <= int_cnt_d;
    end
  end
  // ==========================================
  // registered outputs
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      charge_en_o <= 1'b0;
      charge_state_o <= CSS_IDLE;
      safety_fault_o <= 1'b0;
      int_o <= 1'b0;
      half_current_o <= 1'b0;
      batreg_mv_o <= 13'h0;
      charge_set_pin_use_reg_o <= 1'b0;
      input_limit_pin_use_reg_o <= 1'b0;
      input_limit_pin_code_o <= 3'h0;
      input_limit_pin_ma_o <= 9'(INPUT_LIMIT_PIN_STEP_MA); // agrees with the code 0 held in reset
      mid_rail_output_en_o <= 1'b0;
      buck_system_output_en_o <= 1'b0;
      aux_switch_output_en_o <= 1'b0;
      host_mode_o <= 1'b0;
      wdog_run_o <= 1'b0;
      defaults_reload_o <= 1'b0;
    end
    else
    begin
      charge_en_o <= ((state_q == CSS_PRE) || (state_q == CSS_FAST)) && !ts_suspend && !ot_q;
      charge_state_o <= state_q;
      safety_fault_o <= fault_q;
      int_o <= (int_cnt_d != 32'h0);
      half_current_o <= ts_cool_zone;
      batreg_mv_o <= batreg_d;
      charge_set_pin_use_reg_o <= charge_set_pin_gnd_i || host_q;
      input_limit_pin_use_reg_o <= input_limit_pin_gnd_i || host_q;
      input_limit_pin_code_o <= (input_limit_pin_gnd_i || host_q) ? input_limit_pin_reg_code_i :
                     input_limit_pin_code_i;
      input_limit_pin_ma_o <= 9'(INPUT_LIMIT_PIN_STEP_MA) * ({6'h0, (input_limit_pin_gnd_i || host_q) ?
                   input_limit_pin_reg_code_i : input_limit_pin_code_i} + 9'h1);
      mid_rail_output_en_o <= !ot_q;
      buck_system_output_en_o <= !ot_q;
      aux_switch_output_en_o <= !ot_q;
      host_mode_o <= host_q;
      wdog_run_o <= wd_run_q;
      defaults_reload_o <= wd_expire;
    end
  end
  // ==========================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  property p_int_pulse;
    $rose(fault_q) |-> int_o ##1 int_o;
  endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("no interrupt on fault");
  property p_fault_hold;
    fault_q && !toggle |=> fault_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault lost early");
  property p_ot_rails;
    ot_q |=> !mid_rail_output_en_o && !buck_system_output_en_o && !aux_switch_output_en_o
             && !charge_en_o;
  endproperty
  a_ot_rails: assert property (p_ot_rails) else $error("rails on in shutdown");
  property p_ot_timer;
    ot_q |=> safe_cnt_q == 32'h0;
  endproperty
  a_ot_timer: assert property (p_ot_timer) else $error("timer runs in shutdown");
  property p_host_input_limit_pin;
    host_q |=> input_limit_pin_use_reg_o && input_limit_pin_code_o == $past(input_limit_pin_reg_code_i);
  endproperty
  a_host_input_limit_pin: assert property (p_host_input_limit_pin) else $error("host limit ignored");
  property p_input_limit_pin_ma;
    input_limit_pin_ma_o == 9'(INPUT_LIMIT_PIN_STEP_MA) * ({6'h0, input_limit_pin_code_o} + 9'h1);
  endproperty
  a_input_limit_pin_ma: assert property (p_input_limit_pin_ma) else $error("limit step wrong");
  property p_hiz_wd;
    hiz_mode_i |=> !wd_run_q ##1 !wdog_run_o;
  endproperty
  a_hiz_wd: assert property (p_hiz_wd) else $error("watchdog runs in hiz");
  property p_suspend;
    ts_suspend && running && !restart |=> safe_cnt_q == $past(safe_cnt_q);
  endproperty
  a_suspend: assert property (p_suspend) else $error("timer runs in suspend");
  property p_warm_floor;
    ts_warm_zone && batreg_mv_i >= BR_FLOOR |=> batreg_mv_o >= BR_FLOOR;
  endproperty
  a_warm_floor: assert property (p_warm_floor) else $error("target below floor");
  property p_write_host;
    i2c_write_i |=> host_q ##1 host_mode_o;
  endproperty
  a_write_host: assert property (p_write_host) else $error("write missed host mode");
endmodule

/* design/css_pkg.sv */
// ==========================================
// charge safety supervisor constants
package css_pkg;
  localparam int CLK_NS = 5;
  localparam int INT_PULSE_NS = 128000;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int WDOG_MS = 50000;
  localparam int PRE_DIV = 10;
  localparam int INPUT_LIMIT_PIN_STEP_MA = 50;
  localparam int BATREG_DROP_MV = 140;
  localparam int BATREG_FLOOR_MV = 3600;
  // safety durations per field code, in 1 ms ticks; values are plain defaults
  localparam int SAFE_MS_0 = 1800000;
  localparam int SAFE_MS_1 = 10800000;
  localparam int SAFE_MS_2 = 21600000;
  localparam int SAFE_MS_3 = 32400000;
  // synchroniser lane positions
  localparam int SY_DIE_HOT = 0;
  localparam int SY_DIE_COOLED = 1;
  localparam int SY_THERMISTOR_OFF_LEVEL = 2;
  localparam int SY_TS_HOT = 3;
  localparam int SY_TS_COLD = 4;
  localparam int SY_TS_COOL = 5;
  localparam int SY_TS_WARM = 6;
  localparam int SY_N = 7;
  typedef enum logic [2:0] {
    CSS_IDLE = 3'b000,
    CSS_PRE = 3'b001,
    CSS_FAST = 3'b010,
    CSS_DONE = 3'b011
  } css_state_t;
endpackage

/* tb/css_host_model.sv */
`timescale 1ns/100ps
module css_host_model #(
  parameter int GAP = 10
)(
  // clock
  input wire logic mclk_i,
  // traffic control from the bench
  input wire logic en_i,
  input wire logic wr_i,
  // completed transaction strobes
  output logic txn_o,
  output logic write_o
);
  // ==========================================
  // periodic host traffic
  // gap stays well under the watchdog span so the settings survive
  int cnt_q;
  always_ff @(posedge mclk_i)
  begin
    if (!en_i)
    begin
      cnt_q <= 0;
      txn_o <= 1'b0;
      write_o <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      txn_o <= (cnt_q == 0);
      write_o <= (cnt_q == 0) && wr_i;
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top import css_pkg::*;;
  // ==========================================
  // signals
  logic mclk_i, srst_i, vin_present_i, chip_disable_in_i, charge_req_i, precharge_i;
  logic terminated_i, cc_cv_loop_i, i2c_txn_i, i2c_write_i, hiz_mode_i, slow_timer_enable_i;
  logic input_limit_pin_gnd_i, charge_set_pin_gnd_i, die_hot_i, die_cooled_i;
  logic thermistor_off_level_i, ts_hot_i, ts_cold_i, ts_cool_i, ts_warm_i;
  logic [1:0] safety_duration_field_i;
  logic [2:0] input_limit_pin_reg_code_i, input_limit_pin_code_i, input_limit_pin_code_o, charge_state_o, lim;
  logic [12:0] batreg_mv_i, batreg_mv_o;
  logic [8:0] input_limit_pin_ma_o;
  logic charge_en_o, safety_fault_o, int_o, half_current_o, charge_set_pin_use_reg_o, input_limit_pin_use_reg_o;
  logic mid_rail_output_en_o, buck_system_output_en_o, aux_switch_output_en_o;
  logic host_mode_o, wdog_run_o, defaults_reload_o, host_en, host_wr;
  int mismatches, checks_done, seed, int_hi, reloads, n, h;

  css_supervisor #(.TICK_CYCLES(4), .INT_CYCLES(8), .WDOG_TICKS(5), .SAFE_T0(40),
    .SAFE_T1(80), .SAFE_T2(120), .SAFE_T3(160)) i_dut (.mclk_i, .srst_i, .vin_present_i,
    .chip_disable_in_i, .charge_req_i, .precharge_i, .terminated_i, .cc_cv_loop_i,
    .i2c_txn_i, .i2c_write_i, .hiz_mode_i, .safety_duration_field_i, .slow_timer_enable_i,
    .input_limit_pin_reg_code_i, .input_limit_pin_code_i, .input_limit_pin_gnd_i, .charge_set_pin_gnd_i,
    .batreg_mv_i, .die_hot_i, .die_cooled_i, .thermistor_off_level_i, .ts_hot_i, .ts_cold_i,
    .ts_cool_i, .ts_warm_i, .charge_en_o, .charge_state_o, .safety_fault_o, .int_o,
    .half_current_o, .batreg_mv_o, .charge_set_pin_use_reg_o, .input_limit_pin_use_reg_o, .input_limit_pin_code_o, .input_limit_pin_ma_o,
    .mid_rail_output_en_o, .buck_system_output_en_o, .aux_switch_output_en_o, .host_mode_o,
    .wdog_run_o, .defaults_reload_o);

  css_host_model #(.GAP(10)) i_host (.mclk_i, .en_i(host_en), .wr_i(host_wr),
    .txn_o(i2c_txn_i), .write_o(i2c_write_i));

  // ==========================================
  // helpers
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(negedge mclk_i)
  begin
    if (int_o === 1'b1) int_hi++;
    if (defaults_reload_o === 1'b1) reloads++;
  end

  function automatic logic [12:0] exp_target(input logic [12:0] v);
    if (v > BATREG_FLOOR_MV + BATREG_DROP_MV) return v - 13'(BATREG_DROP_MV);
    if (v > BATREG_FLOOR_MV) return 13'(BATREG_FLOOR_MV);
    return v;
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s exp %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  // bounded wait on the fault flag (sel 0) or the reload strobe (sel 1)
  task automatic wait_lvl(input int sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while ((sel ? defaults_reload_o : safety_fault_o) !== v && cnt < lim)
    begin
      cyc(1);
      cnt++;
    end
    if ((sel ? defaults_reload_o : safety_fault_o) !== v)
    begin
      mismatches++;
      $display("mismatch timeout exp %0h seen %0h", v, sel ? defaults_reload_o : safety_fault_o);
      wrap_up();
    end
  endtask

  task automatic expect_fault(input int lo, input int hi);
    wait_lvl(0, 1'b1, hi + 20, n);
    chk("fault time", 16'(n >= lo && n <= hi), 16'h1);
  endtask

  // toggling the disable input or the input power, or a reset, is the only way out of a safety fault
  task automatic clear_fault(input bit by_power);
    if (by_power)
      vin_present_i = 1'b0;
    else
      chip_disable_in_i = 1'b1;
    cyc(2);
    {vin_present_i, chip_disable_in_i} = 2'b10;
    wait_lvl(0, 1'b0, 10, n);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    seed = 32'hCD385BBB;
    {srst_i, vin_present_i, die_cooled_i} = 3'h7;
    {chip_disable_in_i, charge_req_i, precharge_i, terminated_i, cc_cv_loop_i} = 5'h01;
    {hiz_mode_i, slow_timer_enable_i, input_limit_pin_gnd_i, charge_set_pin_gnd_i} = 4'h0;
    {die_hot_i, thermistor_off_level_i, ts_hot_i, ts_cold_i, ts_cool_i, ts_warm_i} = 6'h00;
    {host_en, host_wr, safety_duration_field_i} = 4'h0;
    {input_limit_pin_reg_code_i, input_limit_pin_code_i, batreg_mv_i} = '0;
    cyc(12);
    chk("charge_en", charge_en_o, 0);
    chk("host_mode", host_mode_o, 0);
    srst_i = 1'b0;
    cyc(4);
    chk("rails", {mid_rail_output_en_o, buck_system_output_en_o, aux_switch_output_en_o}, 7);
    chk("wdog_run", wdog_run_o, 0);
    for (int i = 0; i < 12; i++)
    begin
      input_limit_pin_reg_code_i = 3'($random(seed));
      input_limit_pin_code_i = 3'($random(seed));
      input_limit_pin_gnd_i = 1'($random(seed));
      charge_set_pin_gnd_i = 1'($random(seed));
      cyc(3);
      lim = input_limit_pin_gnd_i ? input_limit_pin_reg_code_i : input_limit_pin_code_i;
      chk("lim_code", input_limit_pin_code_o, lim);
      chk("lim_ma", input_limit_pin_ma_o, 9'((lim + 1) * INPUT_LIMIT_PIN_STEP_MA));
      chk("lim_reg", input_limit_pin_use_reg_o, input_limit_pin_gnd_i);
      chk("set_reg", charge_set_pin_use_reg_o, charge_set_pin_gnd_i);
    end
    for (int i = 0; i < 12; i++)
    begin
      batreg_mv_i = i == 0 ? 13'hE9C : i == 1 ? 13'hE9D : i == 2 ? 13'hE10 :
        13'hDAC + 13'($random(seed) & 32'h1FF);
      {ts_warm_i, ts_cool_i, ts_cold_i, thermistor_off_level_i} = {1'b1, 2'($random(seed)), 1'b0};
      cyc(5);
      chk("target", batreg_mv_o, exp_target(batreg_mv_i));
      chk("half", half_current_o, ts_cool_i & ~ts_cold_i);
      thermistor_off_level_i = 1'b1;
      cyc(5);
      chk("target_off", batreg_mv_o, batreg_mv_i);
      chk("half_off", half_current_o, 0);
    end
    {ts_warm_i, ts_cool_i, ts_cold_i, thermistor_off_level_i, input_limit_pin_gnd_i} = 5'h00;
    {host_en, host_wr} = 2'h3;
    cyc(4);
    host_wr = 1'b0;
    cyc(2);
    chk("host_mode", host_mode_o, 1);
    chk("lim_reg_host", input_limit_pin_use_reg_o, 1);
    chk("lim_code_host", input_limit_pin_code_o, input_limit_pin_reg_code_i);
    cyc(80);
    chk("no_reload", 16'(reloads), 0);
    host_en = 1'b0;
    wait_lvl(1, 1'b1, 60, n);
    chk("wdog_time", 16'(n >= 8 && n <= 28), 1);
    cyc(3);
    chk("host_after", host_mode_o, 0);
    host_en = 1'b1;
    cyc(4);
    chk("wdog_run", wdog_run_o, 1);
    {hiz_mode_i, host_en} = 2'h2;
    cyc(3);
    chk("wdog_hiz", wdog_run_o, 0);
    hiz_mode_i = 1'b0;
    cyc(40);
    chk("wdog_idle", wdog_run_o, 0);
    chk("reloads", 16'(reloads), 1);
    host_en = 1'b1;
    cyc(4);
    chk("wdog_rerun", wdog_run_o, 1);
    host_en = 1'b0;
    cyc(30);
    h = int_hi;
    {charge_req_i, precharge_i} = 2'h3;
    expect_fault(14, 28);
    cyc(12);
    chk("int_width", 16'(int_hi - h), 8);
    chk("state", charge_state_o, 3'(CSS_IDLE));
    chk("charge_en", charge_en_o, 0);
    precharge_i = 1'b0;
    cyc(50);
    chk("fault_hold", safety_fault_o, 1);
    clear_fault(1'b0);
    cyc(100);
    safety_duration_field_i = 2'h1;
    expect_fault(310, 345);
    safety_duration_field_i = 2'h0;
    clear_fault(1'b1);
    cyc(100);
    ts_hot_i = 1'b1;
    cyc(200);
    chk("suspend", charge_en_o, 0);
    ts_hot_i = 1'b0;
    expect_fault(45, 80);
    clear_fault(1'b0);
    cyc(100);
    {die_hot_i, die_cooled_i} = 2'h2;
    cyc(20);
    chk("rails_hot", {mid_rail_output_en_o, buck_system_output_en_o, aux_switch_output_en_o},
      0);
    chk("charge_hot", charge_en_o, 0);
    die_hot_i = 1'b0;
    cyc(20);
    chk("rails_hys", mid_rail_output_en_o, 0);
    {slow_timer_enable_i, cc_cv_loop_i, die_cooled_i} = 3'h5;
    expect_fault(310, 370);
    chk("rails_back", mid_rail_output_en_o, 1);
    slow_timer_enable_i = 1'b0;
    clear_fault(1'b1);
    cyc(40);
    terminated_i = 1'b1;
    cyc(4);
    chk("done_state", charge_state_o, 3'(CSS_DONE));
    cyc(200);
    chk("done_no_fault", safety_fault_o, 0);
    chk("done_charge", charge_en_o, 0);
    wrap_up();
  end

  initial
  begin
    #400000;
    mismatches++;
    wrap_up();
  end
endmodule
